/* hdl/tmc_top.sv */
// Operation
// - clearing input block or digital loop enable powers that part down
// - selector code 0xx puts the device in analog-only mode
// - selector 100 plus both enables gives combined mode
// - source select 1 routes external oscillator pins as master clock
// - source select 0 routes divided second analog loop output
// - master clock divider divides second loop output by 2 or 3
// - second loop output may be routed to any bank A to D
// - both crystal pin enables set runs the oscillator
// - input enable only takes crystal input as single-ended clock
// - frequency offset applied to digital loop in combined mode
// - reset assumes 204.8MHz master clock nominal
// - divider disabled while its field is zero
// - stopped or slow loop input (under 128 edges per 1024 cycles) latches failure flag
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module tmc_top
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // clock sources as edge enables
    input  wire logic        ext_osc_tick_i,
    input  wire logic        loop2_out_tick_i,
    input  wire logic        loop2_ref_tick_i,
    // block controls
    output logic             input_block_power_o,
    output logic             digital_loop_power_o,
    output logic             combined_mode_o,
    output logic             mclk_tick_o,
    output logic [NBANK-1:0] bank_loop2_route_o,
    output logic             crystal_in_enable_o,
    output logic             crystal_out_drive_o,
    output logic             crystal_single_ended_o,
    output logic             ext_osc_enable_o,
    output logic [FREQ_W-1:0] freq_offset_o,
    output logic [HOLD_W-1:0] holdover_timer_o,
    output logic [31:0]      nominal_mclk_khz_o
);
    tmc_cfg_if cfg_if ();

    // ==========================================================
    // registers
    logic [1:0]        mc1_r,   mc1_nxt;
    logic [7:0]        mc2_r,   mc2_nxt;
    logic [7:0]        mc3_r,   mc3_nxt;
    logic [2:0]        sel_r,   sel_nxt;
    logic [FREQ_W-1:0] frq_r,   frq_nxt;
    logic [HOLD_W-1:0] hold_r,  hold_nxt;
    logic [31:0]       nom_r,   nom_nxt;
    logic              fail_r,  fail_nxt;
    logic              aw_r,    aw_nxt;
    logic              w_r,     w_nxt;
    logic [7:0]        awa_r,   awa_nxt;
    logic [31:0]       wd_r,    wd_nxt;
    logic              bv_r,    bv_nxt;
    logic [1:0]        br_r,    br_nxt;
    logic              rv_r,    rv_nxt;
    logic [31:0]       rd_r,    rd_nxt;
    logic [1:0]        rr_r,    rr_nxt;
    logic              fail_ev;
    logic              wr_go;
    logic              wr_clr;
    tmc_mode_t         mode;

    // ==========================================================
    // submodules
    tmc_mclk_div u_div (
        .clk_i        (clk_i),
        .rstn_i       (rstn_i),
        .loop2_tick_i (loop2_out_tick_i),
        .cfg          (cfg_if.div)
    );

    tmc_fail_mon u_mon (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .ref_tick_i (loop2_ref_tick_i),
        .bad_o      (fail_ev)
    );

    assign cfg_if.div_en  = (mc2_r[DIV_LSB +: DIV_W] != DIV_OFF);
    assign cfg_if.div_sel = mc2_r[DIV_LSB +: DIV_W];

    // ==========================================================
    // mode decode
    always_comb begin
        if (!sel_r[2]) begin
            mode = MODE_ANALOG_ONLY;
        end else if (sel_r == SEL_DIGITAL_LOOP && mc1_r[IBE_BIT] && mc1_r[DLE_BIT]) begin
            mode = MODE_COMBINED;
        end else begin
            mode = MODE_INVALID;
        end
    end

    // ==========================================================
    // axi write and read
    assign wr_go  = aw_r && w_r && !bv_r;
    assign wr_clr = wr_go && awa_r == LATCHED_STATUS_OFS && wd_r[FAIL_BIT];

    always_comb begin
        aw_nxt = aw_r;
        w_nxt = w_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        bv_nxt = bv_r;
        br_nxt = br_r;
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        mc1_nxt = mc1_r;
        mc2_nxt = mc2_r;
        mc3_nxt = mc3_r;
        sel_nxt = sel_r;
        frq_nxt = frq_r;
        hold_nxt = hold_r;
        nom_nxt = nom_r;
        if (s_axi_awvalid && !aw_r && !bv_r) begin
            aw_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_r && !bv_r) begin
            w_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
        end
        if (wr_go) begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = 2'b00;
            case (awa_r)
                MAIN_CONTROL_ONE_OFS:    mc1_nxt = wd_r[1:0];
                MAIN_CONTROL_TWO_OFS:    mc2_nxt = wd_r[7:0];
                MAIN_CONTROL_THREE_OFS:  mc3_nxt = wd_r[7:0];
                ANALOG_LOOP_CTL_TWO_OFS: sel_nxt = wd_r[SEL_W-1:0];
                FREQ_OFFSET_OFS:         frq_nxt = wd_r[FREQ_W-1:0];
                HOLDOVER_OFS:            hold_nxt = wd_r[HOLD_W-1:0];
                STATUS_OFS:              nom_nxt = wd_r;
                LATCHED_STATUS_OFS:      br_nxt = 2'b00;
                default:                 br_nxt = 2'b10;
            endcase
        end else if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rv_r) begin
            rv_nxt = 1'b1;
            rr_nxt = 2'b00;
            case (s_axi_araddr)
                MAIN_CONTROL_ONE_OFS:    rd_nxt = {30'h0, mc1_r};
                MAIN_CONTROL_TWO_OFS:    rd_nxt = {24'h0, mc2_r};
                MAIN_CONTROL_THREE_OFS:  rd_nxt = {24'h0, mc3_r};
                ANALOG_LOOP_CTL_TWO_OFS: rd_nxt = {29'h0, sel_r};
                FREQ_OFFSET_OFS:         rd_nxt = {8'h0, frq_r};
                HOLDOVER_OFS:            rd_nxt = {24'h0, hold_r};
                STATUS_OFS:              rd_nxt = nom_r;
                LATCHED_STATUS_OFS:      rd_nxt = {28'h0, 2'(mode), 1'b0, fail_r};
                default: begin
                    rd_nxt = 32'h0;
                    rr_nxt = 2'b10;
                end
            endcase
        end else if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
        // set wins over clear
        fail_nxt = fail_ev ? 1'b1 : (wr_clr ? 1'b0 : fail_r);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awa_r <= 8'h00;
            wd_r <= 32'h0;
            bv_r <= 1'b0;
            br_r <= 2'b00;
            rv_r <= 1'b0;
            rd_r <= 32'h0;
            rr_r <= 2'b00;
            mc1_r <= 2'h0;
            mc2_r <= 8'h00;
            mc3_r <= 8'h00;
            sel_r <= 3'h0;
            frq_r <= '0;
            hold_r <= '0;
            nom_r <= NOMINAL_MCLK_KHZ;
            fail_r <= 1'b0;
        end else begin
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            rr_r <= rr_nxt;
            mc1_r <= mc1_nxt;
            mc2_r <= mc2_nxt;
            mc3_r <= mc3_nxt;
            sel_r <= sel_nxt;
            frq_r <= frq_nxt;
            hold_r <= hold_nxt;
            nom_r <= nom_nxt;
            fail_r <= fail_nxt;
        end
    end

    // ==========================================================
    // block controls, all registered
    logic mt_nxt;
    always_comb begin
        if (mc3_r[MUX_BIT]) begin
            mt_nxt = ext_osc_tick_i && mc2_r[EXT_BIT];
        end else begin
            mt_nxt = cfg_if.mclk_div_pulse;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            input_block_power_o <= 1'b0;
            digital_loop_power_o <= 1'b0;
            combined_mode_o <= 1'b0;
            mclk_tick_o <= 1'b0;
            bank_loop2_route_o <= '0;
            crystal_in_enable_o <= 1'b0;
            crystal_out_drive_o <= 1'b0;
            crystal_single_ended_o <= 1'b0;
            ext_osc_enable_o <= 1'b0;
            freq_offset_o <= '0;
            holdover_timer_o <= '0;
            nominal_mclk_khz_o <= NOMINAL_MCLK_KHZ;
        end else begin
            input_block_power_o <= mc1_r[IBE_BIT];
            digital_loop_power_o <= mc1_r[DLE_BIT];
            combined_mode_o <= (mode == MODE_COMBINED);
            mclk_tick_o <= mt_nxt && (mode == MODE_COMBINED);
            bank_loop2_route_o <= mc3_r[BANK_LSB +: NBANK];
            crystal_in_enable_o <= mc2_r[XI_BIT];
            crystal_out_drive_o <= mc2_r[XI_BIT] && mc2_r[XO_BIT];
            crystal_single_ended_o <= mc2_r[XI_BIT] && !mc2_r[XO_BIT];
            ext_osc_enable_o <= mc2_r[EXT_BIT];
            freq_offset_o <= (mode == MODE_COMBINED) ? frq_r : '0;
            holdover_timer_o <= hold_r;
            nominal_mclk_khz_o <= nom_r;
        end
    end

    assign s_axi_awready = !aw_r && !bv_r;
    assign s_axi_wready  = !w_r && !bv_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = br_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rr_r;

    // ==========================================================
    // checks
    AST_ANALOG_MODE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !sel_r[2] |=> !combined_mode_o) else $error("combined with 0xx selector");
    AST_COMBINED: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel_r == 3'h4 && mc1_r == 2'h3) |=> combined_mode_o) else $error("combined mode missing");
    AST_POWER: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !mc1_r[0] |=> !input_block_power_o) else $error("input block not powered down");
    AST_EXT_ROUTE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mc3_r[0] && mc2_r[2] && ext_osc_tick_i && combined_mode_o && $stable(sel_r) && $stable(mc1_r))
        |=> mclk_tick_o) else $error("external tick not routed");
    AST_DIV_ROUTE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!$past(mc3_r[MUX_BIT]) && mclk_tick_o) |-> $past(cfg_if.mclk_div_pulse)) else $error("bad divided route");
    AST_XTAL_OUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mc2_r[1:0] == 2'h3) |=> crystal_out_drive_o) else $error("crystal not driven");
    AST_XTAL_SE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mc2_r[1:0] == 2'h1) |=> (crystal_single_ended_o && !crystal_out_drive_o))
        else $error("single-ended setup wrong");
    AST_FAIL_LATCH: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fail_ev |=> fail_r) else $error("failure not latched");
    AST_OFFSET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !combined_mode_o |-> freq_offset_o == '0)
        else $error("offset outside combined mode");
endmodule

/* hdl/tmc_pkg.sv */
package tmc_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] MAIN_CONTROL_ONE_OFS   = 8'h00;
    localparam logic [7:0] MAIN_CONTROL_TWO_OFS   = 8'h04;
    localparam logic [7:0] MAIN_CONTROL_THREE_OFS = 8'h08;
    localparam logic [7:0] ANALOG_LOOP_CTL_TWO_OFS = 8'h0C;
    localparam logic [7:0] FREQ_OFFSET_OFS        = 8'h10;
    localparam logic [7:0] HOLDOVER_OFS           = 8'h14;
    localparam logic [7:0] STATUS_OFS             = 8'h18;
    localparam logic [7:0] LATCHED_STATUS_OFS     = 8'h1C;
    // ==========================================================
    // field positions
    localparam int IBE_BIT    = 0;
    localparam int DLE_BIT    = 1;
    localparam int XI_BIT     = 0;
    localparam int XO_BIT     = 1;
    localparam int EXT_BIT    = 2;
    localparam int DIV_LSB    = 4;
    localparam int DIV_W      = 2;
    localparam int MUX_BIT    = 0;
    localparam int SEL_W      = 3;
    localparam int BANK_LSB   = 4;
    localparam int NBANK      = 4;
    localparam int FREQ_W     = 24;
    localparam int HOLD_W     = 8;
    localparam int FAIL_BIT   = 0;
    // ==========================================================
    // codes and reset values
    localparam logic [2:0]  SEL_DIGITAL_LOOP = 3'h4;
    localparam logic [1:0]  DIV_OFF          = 2'h0;
    localparam logic [1:0]  DIV_BY3          = 2'h3;
    localparam logic [31:0] NOMINAL_MCLK_KHZ = 32'h00032000;
    localparam logic [15:0] MON_WINDOW       = 16'h0400;
    localparam logic [15:0] MON_MIN_EDGES    = 16'h0080;
    localparam logic [15:0] MON_MAX_EDGES    = 16'h0800;

    typedef enum logic [1:0] {
        MODE_ANALOG_ONLY = 2'b00,
        MODE_COMBINED    = 2'b01,
        MODE_INVALID     = 2'b10
    } tmc_mode_t;
endpackage

/* hdl/tmc_cfg_if.sv */
`timescale 1ns/1ps
interface tmc_cfg_if;
    logic       div_en;
    logic [1:0] div_sel;
    logic       mclk_div_pulse;
    modport ctl (output div_en, output div_sel, input  mclk_div_pulse);
    modport div (input  div_en, input  div_sel, output mclk_div_pulse);
endinterface

/* hdl/tmc_mclk_div.sv */
`timescale 1ns/1ps
module tmc_mclk_div
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // second analog loop edge enable
    input  wire logic loop2_tick_i,
    // configuration
    tmc_cfg_if.div    cfg
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       pls_r;
    logic       pls_nxt;

    // ==========================================================
    // divide by 2 or 3; disabled while field is zero
    always_comb begin
        cnt_nxt = cnt_r;
        pls_nxt = 1'b0;
        if (!cfg.div_en) begin
            cnt_nxt = 2'h0;
        end else if (loop2_tick_i) begin
            if (cnt_r >= ((cfg.div_sel == DIV_BY3) ? 2'h2 : 2'h1)) begin
                cnt_nxt = 2'h0;
                pls_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_r <= 2'h0;
            pls_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pls_r <= pls_nxt;
        end
    end

    assign cfg.mclk_div_pulse = pls_r;

    AST_DIV_OFF_SILENT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !cfg.div_en |=> !pls_r) else $error("divider pulsed while disabled");
endmodule

/* hdl/tmc_fail_mon.sv */
`timescale 1ns/1ps
module tmc_fail_mon
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // second analog loop input edge enable
    input  wire logic ref_tick_i,
    // window result pulse
    output logic      bad_o
);
    logic [15:0] win_r;
    logic [15:0] win_nxt;
    logic [15:0] edg_r;
    logic [15:0] edg_nxt;
    logic        bad_r;
    logic        bad_nxt;

    // ==========================================================
    // count input edges per window; only a stopped or slow input flags bad
    always_comb begin
        win_nxt = win_r + 16'h0001;
        edg_nxt = edg_r;
        bad_nxt = 1'b0;
        if (ref_tick_i && edg_r != 16'hFFFF) begin
            edg_nxt = edg_r + 16'h0001;
        end
        if (win_r == MON_WINDOW - 16'h0001) begin
            win_nxt = 16'h0000;
            edg_nxt = 16'h0000;
            bad_nxt = (edg_r < MON_MIN_EDGES) || (edg_r > MON_MAX_EDGES);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            win_r <= 16'h0000;
            edg_r <= 16'h0000;
            bad_r <= 1'b0;
        end else begin
            win_r <= win_nxt;
            edg_r <= edg_nxt;
            bad_r <= bad_nxt;
        end
    end

    assign bad_o = bad_r;
endmodule

/* dv/tmc_top_bench.sv */
`timescale 1ns/1ps
module tmc_top_bench
    import tmc_pkg::*;
;
    // ==========================================================
    // signals
    logic              clk_i   = 1'b0;
    logic              rstn_i  = 1'b0;
    logic [7:0]        awaddr  = 8'h00;
    logic              awvalid = 1'b0;
    logic [31:0]       wdata   = 32'h0;
    logic              wvalid  = 1'b0;
    logic              bready  = 1'b0;
    logic [7:0]        araddr  = 8'h00;
    logic              arvalid = 1'b0;
    logic              rready  = 1'b0;
    logic              ext_t   = 1'b0;
    logic              l2_t    = 1'b0;
    logic              ref_t   = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata, nom;
    logic              ibp, dlp, comb, mtick, crystal_input_pin, crystal_output_pin, xse, exten;
    logic [NBANK-1:0]  bank;
    logic [FREQ_W-1:0] foff;
    logic [HOLD_W-1:0] hold;
    logic              ref_run = 1'b1;
    logic [1:0]        rc      = 2'h0;
    int                err_total   = 0;
    int                check_count = 0;

    tmc_top dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_osc_tick_i(ext_t), .loop2_out_tick_i(l2_t), .loop2_ref_tick_i(ref_t),
        .input_block_power_o(ibp), .digital_loop_power_o(dlp), .combined_mode_o(comb),
        .mclk_tick_o(mtick), .bank_loop2_route_o(bank), .crystal_in_enable_o(crystal_input_pin),
        .crystal_out_drive_o(crystal_output_pin), .crystal_single_ended_o(xse), .ext_osc_enable_o(exten),
        .freq_offset_o(foff), .holdover_timer_o(hold), .nominal_mclk_khz_o(nom)
    );

    // ==========================================================
    // clock, reference ticks, watchdog
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // one reference edge every four cycles keeps the monitor content
    always @(posedge clk_i) begin
        rc    <= rc + 2'h1;
        ref_t <= ref_run && (rc == 2'h0);
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        end_sim();
    end

    // ==========================================================
    // common tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta;
        bit tw;
        ta = 0;
        tw = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk_i);
            if (awvalid && awready === 1'b1) ta = 1;
            if (wvalid && wready === 1'b1) tw = 1;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge clk_i);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ta;
        ta = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!ta) begin
            @(posedge clk_i);
            if (arready === 1'b1) ta = 1;
            if (ta) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1) @(posedge clk_i);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk(32'(r), 32'(er));
    endtask

    // drives loop and oscillator ticks, counts master clock pulses
    task automatic burst(input logic xe, input logic xl, input int nt, output int c);
        int i;
        c = 0;
        for (i = 0; i < nt + 6; i++) begin
            ext_t <= xe && (i < nt);
            l2_t  <= xl && (i < nt);
            @(posedge clk_i);
            if (mtick === 1'b1) c++;
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        int i;
        for (i = 0; i < 8; i++) rdc(8'(i * 4), (i == 6) ? NOMINAL_MCLK_KHZ : 32'h0, 2'h0);
        chk(nom, 32'h00032000);
        chk(32'({ibp, dlp, comb, mtick}), 32'h0);
        rdc(8'h20, 32'h0, 2'h2);
        wr(8'h24, 32'h1, 2'h2);
    endtask

    task automatic t_mode();
        int s;
        int e;
        logic [1:0] m;
        wr(FREQ_OFFSET_OFS, 32'h00ABCDEF, 2'h0);
        for (s = 0; s < 8; s++) begin
            for (e = 0; e < 4; e++) begin
                wr(MAIN_CONTROL_ONE_OFS, 32'(e), 2'h0);
                wr(ANALOG_LOOP_CTL_TWO_OFS, 32'(s), 2'h0);
                m = !s[2] ? MODE_ANALOG_ONLY : (s == 4 && e == 3) ? MODE_COMBINED : MODE_INVALID;
                chk(32'({dlp, ibp}), 32'(e));
                chk(32'(comb), 32'(m == MODE_COMBINED));
                chk(32'(foff), (m == MODE_COMBINED) ? 32'h00ABCDEF : 32'h0);
                rdc(LATCHED_STATUS_OFS, 32'({m, 2'b00}), 2'h0);
            end
        end
    endtask

    task automatic t_xtal();
        logic [2:0] v [5] = '{3'h3, 3'h1, 3'h0, 3'h4, 3'h7};
        int i;
        for (i = 0; i < 5; i++) begin
            wr(MAIN_CONTROL_TWO_OFS, 32'(v[i]), 2'h0);
            chk(32'({crystal_input_pin, crystal_output_pin}), 32'({v[i][0], v[i][0] & v[i][1]}));
            chk(32'({xse, exten}), 32'({v[i][0] & ~v[i][1], v[i][2]}));
            rdc(MAIN_CONTROL_TWO_OFS, 32'(v[i]), 2'h0);
        end
        for (i = 0; i < 16; i++) begin
            wr(MAIN_CONTROL_THREE_OFS, 32'(i << 4), 2'h0);
            chk(32'(bank), 32'(i));
        end
        wr(HOLDOVER_OFS, 32'h0000005A, 2'h0);
        chk(32'(hold), 32'h5A);
        wr(STATUS_OFS, 32'h00030D40, 2'h0);
        chk(nom, 32'h00030D40);
    endtask

    task automatic t_clock();
        int c;
        int d;
        wr(MAIN_CONTROL_ONE_OFS, 32'h3, 2'h0);
        wr(ANALOG_LOOP_CTL_TWO_OFS, 32'(SEL_DIGITAL_LOOP), 2'h0);
        wr(MAIN_CONTROL_TWO_OFS, 32'h4, 2'h0);
        wr(MAIN_CONTROL_THREE_OFS, 32'h1, 2'h0);
        ext_t <= 1'b1;
        @(posedge clk_i);
        ext_t <= 1'b0;
        @(posedge clk_i);
        chk(32'(mtick), 32'h1);
        @(posedge clk_i);
        chk(32'(mtick), 32'h0);
        burst(1'b1, 1'b1, 8, c);
        chk(32'(c), 32'h8);
        wr(MAIN_CONTROL_THREE_OFS, 32'h0, 2'h0);
        burst(1'b1, 1'b0, 8, c);
        chk(32'(c), 32'h0);
        for (d = 0; d < 4; d++) begin
            wr(MAIN_CONTROL_TWO_OFS, 32'((d << DIV_LSB) | 4), 2'h0);
            burst(1'b0, 1'b1, 12, c);
            chk(32'(c), (d == 0) ? 32'h0 : (d == 3) ? 32'h4 : 32'h6);
        end
        wr(ANALOG_LOOP_CTL_TWO_OFS, 32'h0, 2'h0);
        burst(1'b1, 1'b1, 8, c);
        chk(32'(c), 32'h0);
    endtask

    task automatic t_fail();
        logic [31:0] d;
        logic [1:0]  r;
        ref_run <= 1'b0;
        repeat (2200) @(posedge clk_i);
        rd(LATCHED_STATUS_OFS, d, r);
        chk(d & 32'h1, 32'h1);
        ref_run <= 1'b1;
        repeat (2200) @(posedge clk_i);
        rd(LATCHED_STATUS_OFS, d, r);
        chk(d & 32'h1, 32'h1);
        wr(LATCHED_STATUS_OFS, 32'h1, 2'h0);
        repeat (1100) @(posedge clk_i);
        rd(LATCHED_STATUS_OFS, d, r);
        chk(d & 32'h1, 32'h0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_mode();
        t_xtal();
        t_clock();
        t_fail();
        end_sim();
    end
endmodule
